// ===== verilog/multimode_serial_port.sv
// Purpose: four-mode serial port with receive holding register and address filter
// Assumes: software strobes are one-cycle pulses on clk; pins are asynchronous
// Notes: timer ticks are on-clock enables; serial_in_pin passes two flip-flops
// What this block does
// - keep a received byte in a holding register; flag overrun and keep old byte when async frame ends with done set, filter off
// - one data port: write feeds transmit, read returns receive register
// - set tx and rx done flags; only software writes clear them
// - mode field picks sync mode or three async modes
// - mode 0 carries data half-duplex on receive pin, clock on transmit pin
// - mode 0 write sends eight bits lsb first, done after eighth bit
// - mode 0 receive starts with enable set, done clear; halts after byte
// - mode 0 rate is clock over twelve, data pin open-drain
// - mode 1 frame is start, eight data lsb first, stop
// - async write starts transmit; done set as stop bit time begins
// - mode 1 load needs done clear and, with filtering, a high stop
// - failed load leaves buffer, ninth bit and done flag untouched
// - mode 1 rate from 8-bit or 16-bit auto-reload timer overflows
// - separate two-bit fields pick transmit and receive rate sources
// - timer overflow rate divided by sixteen gives bit rate
// - mode 2 frame adds a programmable ninth bit before stop
// - ninth bit sent from control bit; received into ninth bit field
// - mode 2 load needs done clear and filter pass on ninth bit
// - mode 2 rate is clock over 64, or over 32 when doubled
// - mode 3 is mode 2 framing with timer rates
// - masked address match compares only mask-one bits
// - broadcast address is address or mask, zeros don't care
// - low stop bit sets framing error in async modes
module multimode_serial_port (
    input wire logic clk,
    input wire logic rst,
    input wire serial_port_pkg::control_type ctrl,
    input wire logic data_write,
    input wire logic [7:0] data_write_value,
    input wire logic clear_tx_done,
    input wire logic clear_rx_done,
    input wire logic clear_errors,
    input wire logic [1:0] timer_tick,
    input wire logic [7:0] timer_one_reload,
    input wire logic [2:0][15:0] wide_timer_reload,
    input wire logic [2:0] wide_timer_clock,
    input wire logic serial_in_pin,
    output logic serial_in_out,
    output logic serial_in_oe,
    output logic serial_out_pin,
    output logic [7:0] serial_data_buffer,
    output serial_port_pkg::status_type status
);

    typedef enum logic [1:0] {TX_IDLE, TX_SHIFT, TX_STOP} tx_phase_type;
    typedef enum logic [1:0] {RX_IDLE, RX_SHIFT, RX_STOP} rx_phase_type;

    typedef struct packed {
        logic [1:0] pin_sync;
        logic pin_prev;
        logic [5:0] fixed_div;
        logic [3:0] sync_div;
        tx_phase_type tx_phase;
        logic [3:0] tx_ovs;
        logic [3:0] tx_count;
        logic [9:0] tx_shift;
        logic tx_line;
        logic sclk;
        logic data_oe;
        rx_phase_type rx_phase;
        logic [3:0] rx_ovs;
        logic [3:0] rx_count;
        logic [8:0] rx_shift;
        logic sync_rx;
        logic [7:0] rx_buf;
        serial_port_pkg::status_type st;
    } state_type;

    state_type s;
    state_type next_s;
    logic [3:0] overflow;

    // ****************************************
    // rate timers: one narrow, three wide
    // ****************************************
    // narrow timer instance
    rate_timer #(.WIDTH(8)) narrow_timer (
        .clk(clk),
        .rst(rst),
        .tick(timer_tick[0]),
        .reload(timer_one_reload),
        .overflow(overflow[0])
    );

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : wide
            rate_timer #(.WIDTH(16)) timer (
                .clk(clk),
                .rst(rst),
                .tick(wide_timer_clock[g] & timer_tick[1]),
                .reload(wide_timer_reload[g]),
                .overflow(overflow[g + 1])
            );
        end
    endgenerate

    function automatic logic addr_match(input logic [7:0] b, input logic [7:0] a,
                                        input logic [7:0] m);
        logic [7:0] bcast;
        bcast = a | m;
        addr_match = (((b ^ a) & m) == 8'h00) || ((b & bcast) == bcast);
    endfunction

    // ****************************************
    // next-state logic
    // ****************************************
    logic sync_mode;
    logic ninth_mode;
    logic fixed_tick;
    logic tx_rate;
    logic rx_rate;
    logic load_ok;
    logic [7:0] rx_byte;

    always_comb begin
        next_s = s;
        sync_mode = (ctrl.mode == serial_port_pkg::MODE_SYNC);
        ninth_mode = ctrl.mode[1];
        fixed_tick = ctrl.rate_double_select ?
            (s.fixed_div[1:0] == 2'(serial_port_pkg::FIXED_DIV_FAST - 1)) :
            (s.fixed_div[1:0] == 2'(serial_port_pkg::FIXED_DIV_SLOW - 1));
        tx_rate = (ctrl.mode == serial_port_pkg::MODE_ASYNC9_FIXED) ? fixed_tick :
            overflow[{ctrl.tx_rate_source_hi, ctrl.tx_rate_source_lo}];
        rx_rate = (ctrl.mode == serial_port_pkg::MODE_ASYNC9_FIXED) ? fixed_tick :
            overflow[{ctrl.rx_rate_source_hi, ctrl.rx_rate_source_lo}];
        load_ok = 1'b0;
        rx_byte = 8'h00;
        next_s.pin_sync = {s.pin_sync[0], serial_in_pin};
        next_s.pin_prev = s.pin_sync[1];
        next_s.fixed_div = fixed_tick ? 6'h00 : s.fixed_div + 6'h01;
        next_s.sync_div = (s.sync_div == 4'(serial_port_pkg::SYNC_DIV - 1)) ?
            4'h0 : s.sync_div + 4'h1;
        // software clears; hardware set below wins
        if (clear_tx_done) next_s.st.tx_done_flag = 1'b0;
        if (clear_rx_done) next_s.st.rx_done_flag = 1'b0;
        if (clear_errors) begin
            next_s.st.framing_error_flag = 1'b0;
            next_s.st.rx_overrun_flag = 1'b0;
        end
        // write to data port starts transmit
        if (data_write && s.tx_phase == TX_IDLE) begin
            next_s.tx_phase = TX_SHIFT;
            next_s.tx_ovs = 4'h0;
            next_s.tx_count = 4'h0;
            next_s.sync_div = 4'h0;
            next_s.sync_rx = 1'b0;
            next_s.tx_shift = {ninth_mode ? ctrl.tx_ninth_bit : 1'b1, data_write_value, 1'b0};
            if (sync_mode) next_s.tx_shift = {2'b11, data_write_value};
        end
        if (sync_mode) begin
            // transmit pin carries the shift clock
            if (s.tx_phase == TX_SHIFT || s.sync_rx) begin
                if (s.sync_div == 4'(serial_port_pkg::SYNC_HALF - 1)) next_s.sclk = 1'b0;
                if (s.sync_div == 4'(serial_port_pkg::SYNC_DIV - 1)) begin
                    next_s.sclk = 1'b1;
                    next_s.rx_count = s.rx_count + 4'h1;
                    if (s.tx_phase == TX_SHIFT) begin
                        next_s.tx_shift = {1'b1, s.tx_shift[9:1]};
                        next_s.tx_count = s.tx_count + 4'h1;
                        // done at end of eighth bit
                        if (s.tx_count == serial_port_pkg::SYNC_BITS - 4'h1) begin
                            next_s.tx_phase = TX_IDLE;
                            next_s.st.tx_done_flag = 1'b1;
                        end
                    end else begin
                        next_s.rx_shift = {1'b0, s.pin_sync[1], s.rx_shift[7:1]};
                        // done one cycle after eighth bit
                        if (s.rx_count == serial_port_pkg::SYNC_BITS - 4'h1) begin
                            next_s.sync_rx = 1'b0;
                            next_s.rx_phase = RX_STOP;
                        end
                    end
                end
            end else if (ctrl.rx_enable_bit && !s.st.rx_done_flag && !data_write
                         && s.rx_phase == RX_IDLE) begin
                next_s.sync_rx = 1'b1;
                next_s.rx_count = 4'h0;
                next_s.sync_div = 4'h0;
            end
            if (s.rx_phase == RX_STOP) begin
                next_s.rx_phase = RX_IDLE;
                next_s.rx_buf = s.rx_shift[7:0];
                next_s.st.rx_done_flag = 1'b1;
            end
            next_s.data_oe = (s.tx_phase == TX_SHIFT) && !next_s.tx_shift[0];
            next_s.tx_line = next_s.sclk;
        end else begin
            next_s.sclk = 1'b1;
            next_s.data_oe = 1'b0;
            next_s.sync_rx = 1'b0;
            if (s.tx_phase != TX_IDLE && tx_rate) begin
                next_s.tx_ovs = s.tx_ovs + 4'h1;
                if (s.tx_ovs == serial_port_pkg::OVS_LAST) begin
                    next_s.tx_shift = {1'b1, s.tx_shift[9:1]};
                    next_s.tx_count = s.tx_count + 4'h1;
                    if (s.tx_count == serial_port_pkg::DATA_BITS + 4'(ninth_mode)) begin
                        next_s.tx_phase = TX_STOP;
                        next_s.st.tx_done_flag = 1'b1;
                    end
                    if (s.tx_phase == TX_STOP) next_s.tx_phase = TX_IDLE;
                end
            end
            next_s.tx_line = (s.tx_phase == TX_IDLE) ? 1'b1 : s.tx_shift[0];
            if (s.rx_phase == RX_IDLE) begin
                if (ctrl.rx_enable_bit && s.pin_prev && !s.pin_sync[1]) begin
                    next_s.rx_phase = RX_SHIFT;
                    next_s.rx_ovs = 4'h0;
                    next_s.rx_count = 4'h0;
                end
            end else if (rx_rate) begin
                next_s.rx_ovs = s.rx_ovs + 4'h1;
                if (s.rx_ovs == serial_port_pkg::SAMPLE_POINT) begin
                    next_s.rx_count = s.rx_count + 4'h1;
                    if (s.rx_count == 4'h0) begin
                        if (s.pin_sync[1]) next_s.rx_phase = RX_IDLE;
                    end else if (s.rx_count <= serial_port_pkg::DATA_BITS + 4'(ninth_mode)) begin
                        next_s.rx_shift = {s.pin_sync[1], s.rx_shift[8:1]};
                    end else begin
                        // stop bit sampled
                        next_s.rx_phase = RX_IDLE;
                        if (!s.pin_sync[1]) next_s.st.framing_error_flag = 1'b1;
                        rx_byte = ninth_mode ? s.rx_shift[7:0] : s.rx_shift[8:1];
                        if (ninth_mode) begin
                            load_ok = !ctrl.addr_filter_enable || (s.rx_shift[8] &&
                                addr_match(rx_byte, ctrl.slave_address_reg,
                                           ctrl.slave_address_mask));
                        end else begin
                            load_ok = !ctrl.addr_filter_enable || s.pin_sync[1];
                        end
                        load_ok = load_ok && !s.st.rx_done_flag;
                        if (load_ok) begin
                            next_s.rx_buf = rx_byte;
                            next_s.st.rx_ninth_bit = ninth_mode ? s.rx_shift[8] : s.pin_sync[1];
                            next_s.st.rx_done_flag = 1'b1;
                        end
                        if (!ctrl.addr_filter_enable && s.st.rx_done_flag)
                            next_s.st.rx_overrun_flag = 1'b1;
                    end
                end
            end
        end
        next_s.st.tx_busy = (next_s.tx_phase != TX_IDLE);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
            s.pin_sync <= 2'b11;
            s.pin_prev <= 1'b1;
            s.tx_line <= 1'b1;
            s.sclk <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign serial_out_pin = s.tx_line;
    assign serial_in_out = 1'b0;
    assign serial_in_oe = s.data_oe;
    assign serial_data_buffer = s.rx_buf;
    assign status = s.st;

    // ****************************************
    // assertions
    // ****************************************
    property p_done_sticky;
        @(posedge clk) disable iff (rst)
        (status.rx_done_flag && !clear_rx_done) |=> status.rx_done_flag;
    endproperty
    a_done_sticky: assert property (p_done_sticky) else $error("rx done dropped");

    property p_idle_high;
        @(posedge clk) disable iff (rst)
        (ctrl.mode != serial_port_pkg::MODE_SYNC && s.tx_phase == TX_IDLE
         && $past(s.tx_phase) == TX_IDLE && $stable(ctrl.mode)) |-> serial_out_pin;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("line not idle high");

    property p_open_drain;
        @(posedge clk) disable iff (rst)
        ctrl.mode != serial_port_pkg::MODE_SYNC |=> ##1 !serial_in_oe or
            $changed(ctrl.mode);
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("data pin driven");

    property p_no_load_when_full;
        @(posedge clk) disable iff (rst)
        (status.rx_done_flag && !clear_rx_done && ctrl.mode != serial_port_pkg::MODE_SYNC)
            |=> $stable(serial_data_buffer);
    endproperty
    a_no_load_when_full: assert property (p_no_load_when_full) else $error("overwrote");

    property p_tx_starts;
        @(posedge clk) disable iff (rst)
        (data_write && s.tx_phase == TX_IDLE) |=> status.tx_busy;
    endproperty
    a_tx_starts: assert property (p_tx_starts) else $error("write did not start");

    property p_sync_byte_time;
        @(posedge clk) disable iff (rst)
        (ctrl.mode == serial_port_pkg::MODE_SYNC && data_write && s.tx_phase == TX_IDLE
         && !clear_tx_done) |-> ##[1:97] status.tx_done_flag;
    endproperty
    a_sync_byte_time: assert property (p_sync_byte_time) else $error("sync byte late");

    property p_done_after_shift;
        @(posedge clk) disable iff (rst)
        $rose(status.tx_done_flag) |-> $past(status.tx_busy);
    endproperty
    a_done_after_shift: assert property (p_done_after_shift) else $error("stray done");

    property p_ovf_reload;
        @(posedge clk) disable iff (rst)
        overflow[0] |-> $past(timer_tick[0]);
    endproperty
    a_ovf_reload: assert property (p_ovf_reload) else $error("overflow without tick");

    c_sync_tx: cover property (@(posedge clk) disable iff (rst)
        ctrl.mode == serial_port_pkg::MODE_SYNC && $rose(status.tx_done_flag));
    c_async_rx: cover property (@(posedge clk) disable iff (rst)
        ctrl.mode != serial_port_pkg::MODE_SYNC && $rose(status.rx_done_flag));
    c_frame_err: cover property (@(posedge clk) disable iff (rst)
        $rose(status.framing_error_flag));

endmodule

// ===== verilog/serial_port_pkg.sv
// Purpose: shared constants and carriers for the multimode serial port
// Assumes: single 125 MHz clock, synchronous active-high reset
// Notes: pin directions follow the active operating mode
package serial_port_pkg;

    // ****************************************
    // modes and rate sources
    // ****************************************
    typedef enum logic [1:0] {
        MODE_SYNC = 2'h0,
        MODE_ASYNC8 = 2'h1,
        MODE_ASYNC9_FIXED = 2'h2,
        MODE_ASYNC9_VAR = 2'h3
    } mode_type;

    localparam logic [1:0] SRC_TIMER_ONE = 2'h0;
    localparam int SYNC_DIV = 12;
    localparam int SYNC_HALF = 6;
    localparam int FIXED_DIV_SLOW = 4;
    localparam int FIXED_DIV_FAST = 2;
    localparam int OVERSAMPLE = 16;
    localparam logic [3:0] SAMPLE_POINT = 4'h7;
    localparam logic [3:0] OVS_LAST = 4'hF;
    localparam logic [7:0] NARROW_TOP = 8'hFF;
    localparam logic [15:0] WIDE_TOP = 16'hFFFF;
    localparam logic [3:0] SYNC_BITS = 4'h8;
    localparam logic [3:0] DATA_BITS = 4'h8;

    // ****************************************
    // software control, status and narrow timer carriers
    // ****************************************
    typedef struct packed {
        mode_type mode;
        logic addr_filter_enable;
        logic rx_enable_bit;
        logic tx_ninth_bit;
        logic rate_double_select;
        logic tx_rate_source_hi;
        logic tx_rate_source_lo;
        logic rx_rate_source_hi;
        logic rx_rate_source_lo;
        logic [7:0] slave_address_reg;
        logic [7:0] slave_address_mask;
    } control_type;

    typedef struct packed {
        logic tx_done_flag;
        logic rx_done_flag;
        logic rx_ninth_bit;
        logic framing_error_flag;
        logic rx_overrun_flag;
        logic tx_busy;
    } status_type;

    typedef struct packed {
        logic [7:0] reload;
        logic [7:0] count;
    } narrow_timer_type;

endpackage

// ===== verilog/rate_timer.sv
// Purpose: auto-reload timer whose rollover paces the serial bit clock
// Assumes: timer clock enable comes from logic on clk
// Notes: width parameter gives 8-bit or 16-bit flavour
module rate_timer #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic [WIDTH-1:0] reload,
    output logic overflow
);

    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic overflow;
    } timer_state_type;

    timer_state_type state;
    timer_state_type next_state;

    // ****************************************
    // rollover from all ones reloads
    // ****************************************
    always_comb begin
        next_state = state;
        next_state.overflow = 1'b0;
        if (tick) begin
            if (&state.count) begin
                next_state.count = reload;
                next_state.overflow = 1'b1;
            end else begin
                next_state.count = state.count + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            // start at top so the first tick reloads, no full-width wait
            state <= '{count: '1, overflow: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    assign overflow = state.overflow;

endmodule

// ===== verif/remote_serial.sv
// Purpose: remote serial party on the far side of the port
// Assumes: bit period is given in clk cycles
// Notes: line rests at the pull-up level between frames
module remote_serial (
    input wire logic clk,
    input wire logic sclk,
    output logic line
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************
    // frame sender
    // ****************
    initial begin
        line = 1'b1;
    end

    task automatic send(input logic [10:0] f, input int n, input int per);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            line = f[i];
            repeat (per - 1) @(negedge clk);
        end
        @(negedge clk);
        line = 1'b1;
    endtask

    // shift on our mode 0 clock, change data while it is low
    task automatic shift_out(input logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            @(negedge sclk);
            @(negedge clk);
            line = d[i];
        end
        @(posedge sclk);
        @(negedge clk);
        line = 1'b1;
    endtask
endmodule

// ===== verif/tb_top.sv
// Purpose: self-checking bench for the multimode serial port
// Assumes: timers tick every clock, reload one below top
// Notes: both timer flavours then give 32 clocks per bit
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, rst, data_write, clear_tx_done, clear_rx_done, clear_errors;
    serial_port_pkg::control_type ctrl;
    serial_port_pkg::status_type status;
    logic [7:0] data_write_value, serial_data_buffer;
    logic serial_in_out, serial_in_oe, serial_out_pin, remote_line;
    int miscompares = 0;
    int tests_run = 0;
    int bit_len = 32;
    // open-drain line, pull-up wins when nobody pulls low
    wire logic rx_wire = serial_in_oe ? serial_in_out : remote_line;

    multimode_serial_port u_multimode_serial_port (
        .clk(clk), .rst(rst), .ctrl(ctrl), .data_write(data_write),
        .data_write_value(data_write_value), .clear_tx_done(clear_tx_done),
        .clear_rx_done(clear_rx_done), .clear_errors(clear_errors),
        .timer_tick(2'h3), .timer_one_reload(8'hFE),
        .wide_timer_reload(48'hFFFEFFFEFFFE), .wide_timer_clock(3'h7),
        .serial_in_pin(rx_wire), .serial_in_out(serial_in_out),
        .serial_in_oe(serial_in_oe), .serial_out_pin(serial_out_pin),
        .serial_data_buffer(serial_data_buffer), .status(status)
    );
    remote_serial u_remote_serial (.clk(clk), .sclk(serial_out_pin), .line(remote_line));

    // ****************
    // helpers
    // ****************
    task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic stop_test;
        if (miscompares == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask

    task automatic tx_frame(input logic [7:0] d, input int n);
        logic [10:0] f;
        int k;
        f = (n == 10) ? {2'b11, d, 1'b0} : {1'b1, ctrl.tx_ninth_bit, d, 1'b0};
        data_write_value = d;
        pulse(data_write);
        k = 0;
        while (serial_out_pin !== 1'b0 && k < 400) begin
            @(negedge clk);
            k++;
        end
        repeat (bit_len / 2) @(negedge clk);
        chk("tx busy", status.tx_busy, 1'b1);
        chk("async oe", serial_in_oe, 1'b0);
        for (int i = 0; i < n; i++) begin
            chk("tx bit", serial_out_pin, f[i]);
            if (i >= n - 2) begin
                chk("tx done", status.tx_done_flag, i == n - 1);
            end
            repeat (bit_len) @(negedge clk);
        end
        pulse(clear_tx_done);
        chk("tx done clear", status.tx_done_flag, 1'b0);
    endtask

    task automatic rx_frame(input logic [7:0] d, input logic b9, input logic stp,
                            input int n, input logic [7:0] exp, input logic ld);
        logic [10:0] f;
        f = (n == 10) ? {1'b1, stp, d, 1'b0} : {stp, b9, d, 1'b0};
        u_remote_serial.send(f, n, bit_len);
        repeat (4) @(negedge clk);
        chk("rx buffer", serial_data_buffer, exp);
        chk("rx done", status.rx_done_flag, ld);
    endtask

    // ****************
    // scenarios
    // ****************
    task automatic t_mode2;
        ctrl.mode = serial_port_pkg::MODE_ASYNC9_FIXED;
        ctrl.rx_enable_bit = 1'b1;
        ctrl.tx_ninth_bit = 1'b1;
        tx_frame(8'hA5, 11);
        bit_len = 64;
        ctrl.rate_double_select = 1'b0;
        ctrl.tx_ninth_bit = 1'b0;
        tx_frame(8'h81, 11);
        bit_len = 32;
        ctrl.rate_double_select = 1'b1;
        rx_frame(8'h3C, 1'b1, 1'b1, 11, 8'h3C, 1'b1);
        chk("rx ninth", status.rx_ninth_bit, 1'b1);
        rx_frame(8'h55, 1'b0, 1'b1, 11, 8'h3C, 1'b1);
        chk("overrun", status.rx_overrun_flag, 1'b1);
        chk("ninth kept", status.rx_ninth_bit, 1'b1);
        pulse(clear_rx_done);
        pulse(clear_errors);
        chk("overrun clear", status.rx_overrun_flag, 1'b0);
    endtask

    task automatic t_filter;
        ctrl.addr_filter_enable = 1'b1;
        rx_frame(8'h1F, 1'b1, 1'b1, 11, 8'h3C, 1'b0);
        rx_frame(8'hF5, 1'b0, 1'b1, 11, 8'h3C, 1'b0);
        rx_frame(8'hF5, 1'b1, 1'b1, 11, 8'hF5, 1'b1);
        pulse(clear_rx_done);
        rx_frame(8'hFF, 1'b1, 1'b1, 11, 8'hFF, 1'b1);
        pulse(clear_rx_done);
    endtask

    task automatic t_mode1;
        ctrl.mode = serial_port_pkg::MODE_ASYNC8;
        tx_frame(8'h5A, 10);
        rx_frame(8'h77, 1'b0, 1'b0, 10, 8'hFF, 1'b0);
        chk("frame error", status.framing_error_flag, 1'b1);
        pulse(clear_errors);
        ctrl.addr_filter_enable = 1'b0;
        rx_frame(8'h77, 1'b0, 1'b1, 10, 8'h77, 1'b1);
        chk("stop in ninth", status.rx_ninth_bit, 1'b1);
        pulse(clear_rx_done);
    endtask

    task automatic t_mode3;
        ctrl.mode = serial_port_pkg::MODE_ASYNC9_VAR;
        ctrl.tx_rate_source_lo = 1'b1;
        ctrl.rx_rate_source_lo = 1'b1;
        tx_frame(8'hC3, 11);
        rx_frame(8'h99, 1'b0, 1'b1, 11, 8'h99, 1'b1);
        chk("m3 ninth", status.rx_ninth_bit, 1'b0);
        pulse(clear_rx_done);
    endtask

    task automatic t_mode0;
        logic v;
        int k, t0;
        ctrl.mode = serial_port_pkg::MODE_SYNC;
        ctrl.rx_enable_bit = 1'b0;
        data_write_value = 8'h96;
        pulse(data_write);
        k = 0;
        t0 = 0;
        for (int i = 0; i < 8; i++) begin
            while (serial_out_pin !== 1'b0 && k < 300) begin
                @(negedge clk);
                k++;
            end
            while (serial_out_pin !== 1'b1 && k < 300) begin
                v = rx_wire;
                @(negedge clk);
                k++;
            end
            if (i == 0) begin
                t0 = k;
            end
            chk("sync bit", v, data_write_value[i]);
        end
        chk("sync span", k - t0, 84);
        repeat (24) @(negedge clk);
        chk("sync done", status.tx_done_flag, 1'b1);
        // receive on our clock, then halt until cleared
        ctrl.rx_enable_bit = 1'b1;
        u_remote_serial.shift_out(8'h6B);
        repeat (4) @(negedge clk);
        chk("sync rx buffer", serial_data_buffer, 8'h6B);
        chk("sync rx done", status.rx_done_flag, 1'b1);
        repeat (30) @(negedge clk);
        chk("sync halt", serial_out_pin, 1'b1);
        ctrl.rx_enable_bit = 1'b0;
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        repeat (40000) @(negedge clk);
        miscompares++;
        stop_test;
    end

    initial begin
        rst = 1'b1;
        ctrl = '0;
        ctrl.slave_address_reg = 8'h35;
        ctrl.slave_address_mask = 8'h0F;
        ctrl.rate_double_select = 1'b1;
        {data_write, clear_tx_done, clear_rx_done, clear_errors} = 4'h0;
        data_write_value = 8'h00;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        chk("idle pin", serial_out_pin, 1'b1);
        chk("idle status", status, 6'h00);
        chk("idle buffer", serial_data_buffer, 8'h00);
        t_mode2;
        t_filter;
        t_mode1;
        t_mode3;
        t_mode0;
        stop_test;
    end
endmodule
